// File: alnp_regs.sv
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module alnp_regs (
   // Clock and reset.
   input  wire logic        sys_clk_in,
   input  wire logic        reset_n_in,
   // AHB-Lite slave.
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic        hready_in,
   input  wire logic [31:0] hwdata_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   // Received page from the negotiation logic, same clock.
   input  wire logic        page_rx_valid_in,
   input  wire logic        page_rx_next_in,
   input  wire logic [15:0] page_rx_word_in,
   // Outgoing page towards the negotiation logic, and the received-page flag.
   input  wire logic        tx_word_taken_in,
   output logic      [15:0] tx_word_out,
   output logic             tx_word_valid_out,
   output logic             page_rx_flag_out
);

   // All state of the bank in one record.
   typedef struct packed {
      logic [15:0]       tx_word;
      logic              tx_valid;
      logic [15:0]       rx_word;
      logic              page_rx;
      logic [15:0][15:0] ps;
      logic              dp_valid;
      logic              dp_write;
      logic [4:0]        dp_idx;
      logic [31:0]       hrdata;
      logic              hreadyout;
   } alnp_state_s;

   alnp_state_s state;
   alnp_state_s next_state;

   // Product registers that exist at all, reserved slots excluded.
   function automatic logic ps_mapped(input logic [4:0] idx);
      logic hit;
      hit = 1'b0;
      unique case (idx)
         alnp_pkg::IDX_PORT_CFG,
         alnp_pkg::IDX_STATUS2,
         alnp_pkg::IDX_INT_EN,
         alnp_pkg::IDX_STAT_CHG,
         alnp_pkg::IDX_IND_CFG,
         alnp_pkg::IDX_DIG_CFG,
         alnp_pkg::IDX_TX_CTRL: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Product registers that hold software data; the two status slots are fed by
   // logic outside this bank and read zero here.
   function automatic logic ps_writable(input logic [4:0] idx);
      logic hit;
      hit = ps_mapped(idx);
      if (idx == alnp_pkg::IDX_STATUS2 || idx == alnp_pkg::IDX_STAT_CHG) begin
         hit = 1'b0;
      end
      return hit;
   endfunction

   // Slot of a product register in the local storage.
   function automatic logic [3:0] ps_slot(input logic [4:0] idx);
      logic [4:0] off;
      off = idx - alnp_pkg::IDX_PS_FIRST;
      return off[3:0];
   endfunction

   // Index field of a bus address.
   logic [4:0] addr_idx;
   logic       addr_in_window;
   logic       addr_phase;
   logic       addr_ok;

   // Address phase decode; the address is taken only when the bus is ready.
   assign addr_idx       = haddr_in[alnp_pkg::ADDR_IDX_MSB:alnp_pkg::ADDR_IDX_LSB];
   assign addr_in_window = (haddr_in[31:alnp_pkg::ADDR_TOP_LSB] == 25'h0000000);
   assign addr_phase     = hsel_in && hready_in && htrans_in[1];
   assign addr_ok        = addr_phase && addr_in_window && (hsize_in == alnp_pkg::HSIZE_WORD);

   // Next state. The order of the steps sets the priorities: the transmit handoff
   // clear, then the pending write, then the read with its clear, then the page
   // event, so that a hardware set always wins over a clear in the same cycle and
   // a read that follows a write back to back sees the written value.
   always_comb begin
      logic [15:0] rd;
      rd         = 16'h0000;
      next_state = state;

      // The negotiation logic has consumed the outgoing word.
      if (tx_word_taken_in) begin
         next_state.tx_valid = 1'b0;
      end

      // Data phase of a write; the address was latched one cycle earlier.
      if (state.dp_valid && state.dp_write) begin
         if (state.dp_idx == alnp_pkg::IDX_NP_TX) begin
            next_state.tx_word[alnp_pkg::BIT_MORE_PAGES] = hwdata_in[alnp_pkg::BIT_MORE_PAGES];
            next_state.tx_word[alnp_pkg::BIT_MESSAGE_PAGE] = hwdata_in[alnp_pkg::BIT_MESSAGE_PAGE];
            next_state.tx_word[alnp_pkg::BIT_COMPLY] = hwdata_in[alnp_pkg::BIT_COMPLY];
            next_state.tx_word[alnp_pkg::BIT_TOGGLE] = hwdata_in[alnp_pkg::BIT_TOGGLE];
            next_state.tx_word[alnp_pkg::CODE_MSB:alnp_pkg::CODE_LSB] =
               hwdata_in[alnp_pkg::CODE_MSB:alnp_pkg::CODE_LSB];
            next_state.tx_word = next_state.tx_word & alnp_pkg::NP_TX_WMASK;
            next_state.tx_valid = 1'b1;
         end else if (ps_writable(state.dp_idx)) begin
            next_state.ps[ps_slot(state.dp_idx)] = hwdata_in[15:0];
         end
      end

      // Address phase bookkeeping for the data phase that follows.
      next_state.dp_valid = addr_ok;
      next_state.dp_write = addr_ok && hwrite_in;
      next_state.dp_idx   = addr_idx;

      // Read data is prepared here so it stands on hrdata during the data phase.
      if (addr_ok && !hwrite_in) begin
         unique case (addr_idx)
            alnp_pkg::IDX_EXPANSION: begin
               rd[alnp_pkg::BIT_NP_ABLE] = alnp_pkg::NP_ABLE_VAL;
               rd[alnp_pkg::BIT_PAGE_RX] = state.page_rx;
               next_state.page_rx = 1'b0;
            end
            alnp_pkg::IDX_NP_TX: begin
               rd = next_state.tx_word;
            end
            alnp_pkg::IDX_NP_RX: begin
               rd = state.rx_word;
            end
            default: begin
               if (ps_writable(addr_idx)) begin
                  rd = next_state.ps[ps_slot(addr_idx)];
               end
            end
         endcase
         next_state.hrdata = {16'h0000, rd};
      end else begin
         next_state.hrdata = 32'h00000000;
      end

      // A new page from the partner; base pages only raise the flag.
      if (page_rx_valid_in) begin
         next_state.page_rx = 1'b1;
         if (page_rx_next_in) begin
            next_state.rx_word = page_rx_word_in;
         end
      end

      // The slave never inserts wait states.
      next_state.hreadyout = 1'b1;

      // Synchronous reset loads constants only.
      if (!reset_n_in) begin
         next_state           = '0;
         next_state.tx_word   = alnp_pkg::NP_TX_RESET;
         next_state.rx_word   = alnp_pkg::NP_RX_RESET;
         next_state.page_rx   = alnp_pkg::PAGE_RX_INIT;
         next_state.ps        = {16{alnp_pkg::PS_RESET}};
         next_state.hreadyout = 1'b1;
      end
   end

   // State register; every bit advances on every edge.
   always_ff @(posedge sys_clk_in) begin
      state <= next_state;
   end

   // Outputs come straight from the state record, except hresp_out, which is tied to HRESP_OKAY.
   assign hrdata_out        = state.hrdata;
   assign hreadyout_out     = state.hreadyout;
   assign hresp_out         = alnp_pkg::HRESP_OKAY;
   assign tx_word_out       = state.tx_word;
   assign tx_word_valid_out = state.tx_valid;
   assign page_rx_flag_out  = state.page_rx;

endmodule

// File: alnp_pkg.sv
// Constants shared by the next-page register bank and its bus slave.
package alnp_pkg;

   // Register indices; the byte address of each register is four times its index.
   localparam logic [4:0] IDX_EXPANSION = 5'h06;
   localparam logic [4:0] IDX_NP_TX     = 5'h07;
   localparam logic [4:0] IDX_NP_RX     = 5'h08;
   localparam logic [4:0] IDX_PORT_CFG  = 5'h10;
   localparam logic [4:0] IDX_STATUS2   = 5'h11;
   localparam logic [4:0] IDX_INT_EN    = 5'h12;
   localparam logic [4:0] IDX_STAT_CHG  = 5'h13;
   localparam logic [4:0] IDX_IND_CFG   = 5'h14;
   localparam logic [4:0] IDX_DIG_CFG   = 5'h1a;
   localparam logic [4:0] IDX_TX_CTRL   = 5'h1e;
   localparam logic [4:0] IDX_PS_FIRST  = 5'h10;

   // Byte address layout on the bus.
   localparam int ADDR_IDX_LSB = 2;
   localparam int ADDR_IDX_MSB = 6;
   localparam int ADDR_TOP_LSB = 7;

   // Field positions inside a next-page code word.
   localparam int BIT_MORE_PAGES   = 15;
   localparam int BIT_ACK          = 14;
   localparam int BIT_MESSAGE_PAGE = 13;
   localparam int BIT_COMPLY       = 12;
   localparam int BIT_TOGGLE       = 11;
   localparam int CODE_MSB         = 10;
   localparam int CODE_LSB         = 0;

   // Field positions inside the expansion register.
   localparam int BIT_NP_ABLE = 2;
   localparam int BIT_PAGE_RX = 1;

   // Reset values.
   localparam logic [15:0] NP_TX_RESET  = 16'h2001;
   localparam logic [15:0] NP_RX_RESET  = 16'h0000;
   localparam logic [15:0] PS_RESET     = 16'h0000;
   localparam logic        NP_ABLE_VAL  = 1'b1;
   localparam logic        PAGE_RX_INIT = 1'b0;

   // Writable bits of the outgoing register; bit 14, the acknowledge bit, is not writable and reads zero.
   localparam logic [15:0] NP_TX_WMASK = 16'hbfff;

   // AHB-Lite encodings.
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// File: alnp_regs_checker.sv
`timescale 1ns/1ps
// Watches bus, page and handoff timing at the bank's ports.
module alnp_regs_checker (
   // Clock, reset and bus.
   input wire logic        sys_clk_in,
   input wire logic        reset_n_in,
   input wire logic        hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0]  htrans_in,
   input wire logic        hwrite_in,
   input wire logic [31:0] hwdata_in,
   input wire logic [31:0] hrdata_out,
   input wire logic        hreadyout_out,
   input wire logic        hresp_out,
   // Page and handoff.
   input wire logic        page_rx_valid_in,
   input wire logic        tx_word_taken_in,
   input wire logic [15:0] tx_word_out,
   input wire logic        tx_word_valid_out,
   input wire logic        page_rx_flag_out
);
   logic       rd_dp;
   logic       wr_dp;
   logic [6:0] dp_a;
   wire        take = hsel_in && htrans_in[1] && haddr_in[31:7] == 25'h0;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   // Remember the accepted address phase; its data phase follows one cycle later.
   always_ff @(posedge sys_clk_in) begin
      rd_dp <= reset_n_in && take && !hwrite_in;
      wr_dp <= reset_n_in && take && hwrite_in;
      dp_a  <= haddr_in[6:0];
   end
   sequence s_wr_tx; take && hwrite_in && haddr_in[6:0] == 7'h1c; endsequence
   sequence s_rd_exp; take && !hwrite_in && haddr_in[6:0] == 7'h18; endsequence
   a_bus_okay: assert property (hreadyout_out && hresp_out == alnp_pkg::HRESP_OKAY)
      else $error("bus stalled or errored");
   a_tx_write: assert property (s_wr_tx |=> ##1 tx_word_valid_out
      && tx_word_out == ($past(hwdata_in[15:0]) & alnp_pkg::NP_TX_WMASK)) else $error("tx word not loaded");
   a_taken_clear: assert property (tx_word_taken_in && !(wr_dp && dp_a == 7'h1c) |=> !tx_word_valid_out)
      else $error("tx valid not cleared");
   a_flag_set: assert property (page_rx_valid_in |=> page_rx_flag_out) else $error("page flag not set");
   a_flag_clear: assert property (s_rd_exp ##0 !page_rx_valid_in |=> !page_rx_flag_out)
      else $error("page flag not cleared");
   a_flag_hold: assert property ($fell(page_rx_flag_out) |-> $past(rd_dp) == 1'b0 && rd_dp && dp_a == 7'h18)
      else $error("page flag dropped");
   a_rd_idle: assert property (!rd_dp |-> hrdata_out == 32'h0) else $error("read data outside phase");
   a_exp_able: assert property (rd_dp && dp_a == 7'h18 |-> hrdata_out[31:3] == 29'h0 && hrdata_out[2])
      else $error("not next page able");
   a_rsvd_zero: assert property (rd_dp && dp_a[6:2] inside {5'h11, 5'h13, [5'h15:5'h19], [5'h1b:5'h1d], 5'h1f}
      |-> hrdata_out == 32'h0) else $error("reserved reads nonzero");
endmodule

// File: alnp_partner.sv
`timescale 1ns/1ps
// Far-side negotiation model: hands pages in and consumes outgoing words.
module alnp_partner (
   // Clock and outgoing word.
   input  wire logic        clk_in,
   input  wire logic        tx_valid_in,
   input  wire logic [15:0] tx_word_in,
   // Received page and handoff.
   output logic             rx_valid_out,
   output logic             rx_next_out,
   output logic      [15:0] rx_word_out,
   output logic             taken_out,
   output logic      [15:0] sent_out
);
   int lag = 0;
   int waited = 0;
   // Quiet lines at time zero.
   initial begin
      rx_valid_out = 1'b0;
      rx_next_out = 1'b0;
      rx_word_out = 16'h0000;
      taken_out = 1'b0;
      sent_out = 16'h0000;
   end
   // One-cycle page pulse; the word is garbled after it so a stale value cannot pass.
   task automatic send(input logic nxt, input logic [15:0] w);
      rx_valid_out <= 1'b1;
      rx_next_out <= nxt;
      rx_word_out <= w;
      @(posedge clk_in);
      rx_valid_out <= 1'b0;
      rx_word_out <= ~w;
   endtask
   // Takes each outgoing word after lag cycles; a large lag is a slow partner.
   always @(posedge clk_in) begin
      waited <= (tx_valid_in === 1'b1 && !taken_out) ? waited + 1 : 0;
      taken_out <= tx_valid_in === 1'b1 && !taken_out && waited >= lag;
      if (tx_valid_in === 1'b1 && !taken_out && waited >= lag) begin
         sent_out <= tx_word_in;
      end
   end
endmodule

// File: alnp_regs_test.sv
`timescale 1ns/1ps
// Software-side checks of the next-page registers.
module alnp_regs_test;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, r;
   logic        hrdy, hresp, rx_v, rx_n, taken, tx_v, flag;
   logic [15:0] rx_w, tx_w, sent;
   int          err_count = 0;
   int          n_compared = 0;
   alnp_regs i_alnp_regs (.sys_clk_in(clk), .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hrdy), .hwdata_in(hwdata),
      .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .page_rx_valid_in(rx_v),
      .page_rx_next_in(rx_n), .page_rx_word_in(rx_w), .tx_word_taken_in(taken), .tx_word_out(tx_w),
      .tx_word_valid_out(tx_v), .page_rx_flag_out(flag));
   alnp_partner i_alnp_partner (.clk_in(clk), .tx_valid_in(tx_v), .tx_word_in(tx_w), .rx_valid_out(rx_v),
      .rx_next_out(rx_n), .rx_word_out(rx_w), .taken_out(taken), .sent_out(sent));
   // Clock and a watchdog against a hung handshake.
   initial forever #12.5 clk = ~clk;
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      wrap_up();
   end
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One single transfer; entered just after a rising edge.
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= alnp_pkg::HTRANS_NONSEQ;
      hsize <= alnp_pkg::HSIZE_WORD;
      haddr <= a;
      hwrite <= wr;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      r = hrdata;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk($sformatf("addr %h", a), r, exp);
   endtask
   // Reset, then reset values, writes, page arrival and the address map.
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk("tx valid", {31'h0, tx_v}, 32'h0);
      chk("page flag", {31'h0, flag}, 32'h0);
      chk("bus response", {31'h0, hresp}, {31'h0, alnp_pkg::HRESP_OKAY});
      rd(32'h1c, 32'h2001);
      rd(32'h20, 32'h0);
      rd(32'h18, 32'h4);
      i_alnp_partner.lag = 3;
      xfer(1'b1, 32'h1c, 32'hffffffff);
      rd(32'h1c, 32'hbfff);
      repeat (8) @(posedge clk);
      chk("sent word", {16'h0, sent}, 32'hbfff);
      chk("tx valid", {31'h0, tx_v}, 32'h0);
      i_alnp_partner.lag = 0;
      xfer(1'b1, 32'h1c, 32'h0);
      rd(32'h1c, 32'h0);
      i_alnp_partner.send(1'b1, 16'hd5a5);
      // The flag is registered at the pulse's edge, so look one edge later.
      @(posedge clk);
      chk("page flag", {31'h0, flag}, 32'h1);
      rd(32'h18, 32'h6);
      chk("page flag", {31'h0, flag}, 32'h0);
      rd(32'h18, 32'h4);
      rd(32'h20, 32'hd5a5);
      i_alnp_partner.send(1'b0, 16'h2a5a);
      xfer(1'b1, 32'h20, 32'hffff);
      rd(32'h20, 32'hd5a5);
      rd(32'h18, 32'h6);
      for (int i = 9; i < 32; i++) begin
         xfer(1'b1, 32'(i * 4), 32'(16'ha5c3 ^ i));
         rd(32'(i * 4), (i inside {16, 18, 20, 26, 30}) ? 32'(16'ha5c3 ^ i) : 32'h0);
      end
      wrap_up();
   end
endmodule
bind alnp_regs alnp_regs_checker i_alnp_regs_checker (.sys_clk_in, .reset_n_in, .hsel_in, .haddr_in,
   .htrans_in, .hwrite_in, .hwdata_in, .hrdata_out, .hreadyout_out, .hresp_out, .page_rx_valid_in,
   .tx_word_taken_in, .tx_word_out, .tx_word_valid_out, .page_rx_flag_out);
